// ---- tor_pkg.sv ----
`default_nettype none
package tor_pkg;

	// ==========================================================
	// geometry
	localparam int AXES = 2;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_MODE   = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MK = 8'h10;
	localparam logic [7:0] ADDR_MAP    = 8'h14;

	// ==========================================================
	// field positions
	localparam int CTRL_BUS_ACT  = 0;
	localparam int CTRL_BUS_ACK  = 2;
	localparam int CTRL_ENABLE   = 4;
	localparam int CTRL_REPORT   = 6;
	localparam int MODE_MANUAL   = 0;
	localparam int MODE_DUAL     = 2;
	localparam int ST_ACTIVE     = 0;
	localparam int ST_REQ        = 2;
	localparam int ST_IOFAIL     = 4;
	localparam int ST_WARN       = 6;
	localparam int ST_FAULT      = 8;
	localparam int IRQ_ON        = 0;
	localparam int IRQ_OFF       = 2;
	localparam int IRQ_IOFAIL    = 4;
	localparam int IRQ_BITS      = 6;

	// ==========================================================
	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [31:0] MAP_RESET  = 32'h0000_0000;
	localparam logic [3:0]  SIN_RESET  = 4'hF;
	localparam logic [1:0]  ACT_RESET  = 2'h3;

	// ==========================================================
	// timing
	localparam int  CLK_MHZ          = 250;
	localparam int  DISAGREE_MS      = 100;
	localparam longint DISAGREE_CYC  = longint'(DISAGREE_MS) * 1000 * CLK_MHZ;
	localparam int  TMR_W            = 25;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		TOR_RUN,
		TOR_OFF,
		TOR_WAIT_ACK,
		TOR_WAIT_EN
	} tor_st_t;

	typedef struct packed {
		logic [1:0] bus_act;
		logic [1:0] stop_act;
		logic [1:0] fault_act;
		logic [3:0] sin;
	} tor_req_t;

	typedef struct packed {
		logic [1:0] stage_en;
		logic [1:0] active;
		logic [1:0] restart_req;
		logic [1:0] iofail;
		logic [1:0] stop_trig;
		logic [3:0] sout;
	} tor_out_t;

endpackage
`default_nettype wire

// ---- tor_ctrl.sv ----
// Function
// - active torque-off disables power stage immediately
// - any activation source turns torque-off on
// - acknowledge only from bus or mapped input
// - per-axis active status output
// - restart request in status and outputs
// - both axes handled independently in one instance
// - per-axis automatic or manual restart mode
// - manual: request, wait ack and enable
// - automatic: restart when released and enabled
// - disagreement over 100 ms raises I/O failure
// - I/O failure warning when disabled, fault when enabled and report bit set
`timescale 1ns/1ps
`default_nettype none
module tor_ctrl #(
	parameter longint DISAGREE_LIMIT = tor_pkg::DISAGREE_CYC
) (
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// activation sources
	input  wire tor_pkg::tor_req_t req,
	// safety outputs
	output tor_pkg::tor_out_t      out,
	output logic                   irq
);
	import tor_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [3:0]        sin_s1;
		logic [3:0]        sin_s2;
		logic [1:0]        bus_ack_q;
		logic [1:0]        ack_q;
		tor_st_t [1:0]     st;
		logic [1:0][TMR_W-1:0] tmr;
		logic [1:0]        iofail;
		logic [31:0]       ctrl;
		logic [31:0]       mode;
		logic [31:0]       map;
		logic [IRQ_BITS-1:0] irq_st;
		logic [IRQ_BITS-1:0] irq_mk;
		logic              dp_act;
		logic              dp_wr;
		logic [7:0]        dp_addr;
		logic [31:0]       hrdata;
		tor_out_t          out;
		logic              irq;
	} tor_state_t;

	tor_state_t r;
	tor_state_t next_r;

	function automatic logic ahb_sel(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic [31:0] rd;
		logic [1:0]  act;
		logic [1:0]  sin_act;
		logic [1:0]  ack_lvl;
		logic [1:0]  ack_rise;
		logic [1:0]  en;
		logic [1:0]  disagree;
		logic [IRQ_BITS-1:0] ev;
		logic [IRQ_BITS-1:0] clr;
		rd       = 32'h0000_0000;
		act      = 2'h0;
		sin_act  = 2'h0;
		ack_lvl  = 2'h0;
		ack_rise = 2'h0;
		en       = 2'h0;
		disagree = 2'h0;
		ev       = '0;
		clr      = '0;
		next_r   = r;

		// two-flop sync of safe inputs
		next_r.sin_s1 = req.sin;
		next_r.sin_s2 = r.sin_s1;

		for (int a = 0; a < AXES; a++) begin
			logic p0;
			logic p1;
			p0 = r.sin_s2[2*a];
			p1 = r.sin_s2[2*a+1];
			en[a] = r.ctrl[CTRL_ENABLE+a];
			// input low means activation (de-energised = safe)
			if (r.mode[MODE_DUAL+a])
				sin_act[a] = ~p0 | ~p1;
			else
				sin_act[a] = ~p0;
			disagree[a] = r.mode[MODE_DUAL+a] & (p0 ^ p1);
			// disagreement timer
			if (!disagree[a])
				next_r.tmr[a] = '0;
			else if (longint'(r.tmr[a]) < DISAGREE_LIMIT)
				next_r.tmr[a] = r.tmr[a] + TMR_W'(1);
			if (disagree[a] && longint'(r.tmr[a]) >= DISAGREE_LIMIT
			    && !r.iofail[a]) begin
				next_r.iofail[a] = 1'b1;
				ev[IRQ_IOFAIL+a] = 1'b1;
			end
			// activation from any source, I/O failure via safe stop
			act[a] = r.ctrl[CTRL_BUS_ACT+a] | req.stop_act[a]
			       | req.fault_act[a] | req.bus_act[a]
			       | (r.map[a] & sin_act[a]) | r.iofail[a];
			// acknowledge only from bus bit or mapped safe input
			ack_lvl[a] = r.ctrl[CTRL_BUS_ACK+a]
			           | (r.map[2+a] & r.sin_s2[2*a]);
			ack_rise[a] = ack_lvl[a] & ~r.ack_q[a];
			next_r.ack_q[a] = ack_lvl[a];

			// per-axis restart sequence
			case (r.st[a])
				TOR_RUN: begin
					if (act[a])
						next_r.st[a] = TOR_OFF;
				end
				TOR_OFF: begin
					if (!act[a]) begin
						if (r.mode[MODE_MANUAL+a])
							next_r.st[a] = TOR_WAIT_ACK;
						else if (en[a])
							next_r.st[a] = TOR_RUN;
						else
							next_r.st[a] = TOR_WAIT_EN;
					end
				end
				TOR_WAIT_ACK: begin
					if (act[a])
						next_r.st[a] = TOR_OFF;
					else if (ack_rise[a])
						next_r.st[a] = en[a] ? TOR_RUN : TOR_WAIT_EN;
				end
				TOR_WAIT_EN: begin
					if (act[a])
						next_r.st[a] = TOR_OFF;
					else if (en[a])
						next_r.st[a] = TOR_RUN;
				end
				default: next_r.st[a] = TOR_OFF;
			endcase
			if (next_r.st[a] != TOR_RUN && r.st[a] == TOR_RUN)
				ev[IRQ_ON+a] = 1'b1;
			if (next_r.st[a] == TOR_RUN && r.st[a] != TOR_RUN)
				ev[IRQ_OFF+a] = 1'b1;

			// outputs follow next state so stage drops same edge
			next_r.out.active[a]      = next_r.st[a] != TOR_RUN;
			next_r.out.stage_en[a]    = next_r.st[a] == TOR_RUN
			                          & ~act[a];
			next_r.out.restart_req[a] = next_r.st[a] == TOR_WAIT_ACK;
			next_r.out.iofail[a]      = next_r.iofail[a];
			next_r.out.stop_trig[a]   = next_r.iofail[a];
			// safe outputs: status on even, restart request on odd
			next_r.out.sout[2*a]      = next_r.st[a] != TOR_RUN;
			next_r.out.sout[2*a+1]    = next_r.st[a] == TOR_WAIT_ACK;
		end

		// ======================================================
		// ahb-lite data phase
		if (r.dp_act) begin
			if (r.dp_wr) begin
				if (ahb_sel(r.dp_addr, ADDR_CTRL))
					next_r.ctrl = hwdata;
				if (ahb_sel(r.dp_addr, ADDR_MODE))
					next_r.mode = hwdata;
				if (ahb_sel(r.dp_addr, ADDR_MAP))
					next_r.map = hwdata;
				if (ahb_sel(r.dp_addr, ADDR_IRQ_MK))
					next_r.irq_mk = hwdata[IRQ_BITS-1:0];
				if (ahb_sel(r.dp_addr, ADDR_IRQ_ST))
					clr = hwdata[IRQ_BITS-1:0];
				if (ahb_sel(r.dp_addr, ADDR_STATUS)) begin
					// write one clears a latched I/O failure unless the inputs still disagree
					for (int a = 0; a < AXES; a++)
						if (hwdata[ST_IOFAIL+a] && !disagree[a])
							next_r.iofail[a] = 1'b0;
				end
			end
		end
		// set wins over clear
		next_r.irq_st = (r.irq_st & ~clr) | ev;
		next_r.irq    = |(next_r.irq_st & next_r.irq_mk);

		// address phase
		next_r.dp_act  = hsel & hready & htrans[1];
		next_r.dp_wr   = hwrite;
		next_r.dp_addr = haddr;
		if (hsel & hready & htrans[1] & !hwrite) begin
			for (int a = 0; a < AXES; a++) begin
				rd[ST_ACTIVE+a] = r.out.active[a];
				rd[ST_REQ+a]    = r.out.restart_req[a];
				rd[ST_IOFAIL+a] = r.iofail[a];
				rd[ST_WARN+a]   = r.iofail[a] & ~r.ctrl[CTRL_ENABLE+a];
				rd[ST_FAULT+a]  = r.iofail[a] & r.ctrl[CTRL_ENABLE+a]
				                & r.ctrl[CTRL_REPORT+a];
			end
			case (haddr)
				ADDR_CTRL:   next_r.hrdata = r.ctrl;
				ADDR_MODE:   next_r.hrdata = r.mode;
				ADDR_STATUS: next_r.hrdata = rd;
				ADDR_IRQ_ST: next_r.hrdata = {26'h0, r.irq_st};
				ADDR_IRQ_MK: next_r.hrdata = {26'h0, r.irq_mk};
				ADDR_MAP:    next_r.hrdata = r.map;
				default:     next_r.hrdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			// idle-high inputs: no false ack edge after reset
			r.sin_s1 <= SIN_RESET;
			r.sin_s2 <= SIN_RESET;
			r.st[0]  <= TOR_OFF;
			r.st[1]  <= TOR_OFF;
			r.ctrl   <= CTRL_RESET;
			r.mode   <= MODE_RESET;
			r.map    <= MAP_RESET;
			r.out.active <= ACT_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign hrdata    = r.hrdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign out       = r.out;
	assign irq       = r.irq;

	// ==========================================================
	// checks
	property p_stage_off;
		@(posedge hclk) disable iff (!hresetn)
		(req.stop_act[0] | req.fault_act[0]) |=> !out.stage_en[0];
	endproperty
	a_stage_off: assert property (p_stage_off) else $error("stage on");

	property p_act_on;
		@(posedge hclk) disable iff (!hresetn)
		(req.bus_act[0] | req.fault_act[0]) |=> out.active[0];
	endproperty
	a_act_on: assert property (p_act_on) else $error("not active");

	property p_stage_vs_active;
		@(posedge hclk) disable iff (!hresetn)
		out.stage_en[0] |-> !out.active[0];
	endproperty
	a_stage_vs_active: assert property (p_stage_vs_active)
		else $error("stage with active");

	property p_req_sout;
		@(posedge hclk) disable iff (!hresetn)
		(out.restart_req[0] == out.sout[1])
		&& (out.restart_req[0] == (r.st[0] == TOR_WAIT_ACK));
	endproperty
	a_req_sout: assert property (p_req_sout) else $error("req mismatch");

	// fresh acknowledge edge on axis 0
	logic ack_edge0;
	assign ack_edge0 = (r.ctrl[CTRL_BUS_ACK] | (r.map[2] & r.sin_s2[0]))
	                 & ~r.ack_q[0];
	property p_manual_hold;
		@(posedge hclk) disable iff (!hresetn)
		(r.st[0] == TOR_WAIT_ACK && !ack_edge0) |=> out.active[0];
	endproperty
	a_manual_hold: assert property (p_manual_hold)
		else $error("left wait");

	property p_auto_run;
		@(posedge hclk) disable iff (!hresetn)
		(r.st[0] == TOR_OFF && !r.mode[MODE_MANUAL]) |=> !out.restart_req[0];
	endproperty
	a_auto_run: assert property (p_auto_run) else $error("auto req");

	property p_iofail_stop;
		@(posedge hclk) disable iff (!hresetn)
		$rose(r.iofail[0]) |-> ##1 (out.stop_trig[0] && out.active[0]);
	endproperty
	a_iofail_stop: assert property (p_iofail_stop) else $error("no stop");

	property p_warn;
		@(posedge hclk) disable iff (!hresetn)
		(hsel && hready && htrans[1] && !hwrite && haddr == ADDR_STATUS
		 && r.iofail[0] && !r.ctrl[CTRL_ENABLE])
		|=> (hrdata[ST_WARN] && !hrdata[ST_FAULT]);
	endproperty
	a_warn: assert property (p_warn) else $error("no warning");

	c_off: cover property (@(posedge hclk) $rose(out.active[0]));
	c_req: cover property (@(posedge hclk) $rose(out.restart_req[0]));
	c_fail: cover property (@(posedge hclk) $rose(out.iofail[0]));
endmodule
`default_nettype wire

// ---- tor_safety_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tor_safety_model #(
	parameter int ACK_DLY = 5
) (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// bench commands
	input  wire logic [1:0] act,
	input  wire logic [1:0] split,
	input  wire logic [1:0] ack_en,
	// device side
	input  wire logic [3:0] sout,
	output logic [3:0]      sin
);
	// ==========================================================
	// acknowledge answer
	logic [7:0] cnt [2];
	logic [1:0] ack_low;
	// low then high pulse gives a fresh edge per request
	always @(posedge hclk or negedge hresetn)
		for (int a = 0; a < 2; a++)
			if (!hresetn || !ack_en[a] || !sout[2*a+1])
				cnt[a] <= 8'h00;
			else if (cnt[a] < ACK_DLY + 4)
				cnt[a] <= cnt[a] + 8'h01;
	always_comb
		for (int a = 0; a < 2; a++) begin
			ack_low[a] = cnt[a] >= ACK_DLY && cnt[a] < ACK_DLY + 4;
			sin[2*a] = !act[a] && !ack_low[a];
			sin[2*a+1] = !act[a] ^ split[a];
		end
endmodule
`default_nettype wire

// ---- tor_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tor_ctrl_tb;
	import tor_pkg::*;
	// ==========================================================
	// signals
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  ba = 2'h0;
	logic [1:0]  sa = 2'h0;
	logic [1:0]  fa = 2'h0;
	logic [1:0]  act = 2'h0;
	logic [1:0]  split = 2'h0;
	logic [1:0]  ack_en = 2'h0;
	logic [3:0]  sin;
	logic [31:0] q;
	tor_req_t    req;
	tor_out_t    out;
	logic        irq;
	int          failures = 0;
	int          compares = 0;
	assign req = {ba, sa, fa, sin};
	always #2 hclk = ~hclk;
	tor_ctrl #(.DISAGREE_LIMIT(20)) u_tor_ctrl (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .req(req), .out(out), .irq(irq));
	tor_safety_model #(.ACK_DLY(5)) u_tor_safety_model (.hclk(hclk),
		.hresetn(hresetn), .act(act), .split(split), .ack_en(ack_en),
		.sout(out.sout), .sin(sin));
	// ==========================================================
	// bus and helpers
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		q = hrdata;
		hsel <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		`CHK(q, e)
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs();
		rdc(ADDR_CTRL, CTRL_RESET);
		rdc(ADDR_MODE, MODE_RESET);
		`CHK(hresp, 1'h0)
		rdc(ADDR_MAP, MAP_RESET);
		rdc(8'h18, 32'h0);
	endtask
	task automatic t_sources();
		wr(ADDR_MAP, 32'h1);
		wr(ADDR_CTRL, 32'h30);
		for (int k = 0; k < 5; k++) begin
			case (k)
			0: ba <= 2'h1;
			1: sa <= 2'h1;
			2: fa <= 2'h1;
			3: wr(ADDR_CTRL, 32'h31);
			default: act <= 2'h1;
			endcase
			w(6);
			`CHK(out.stage_en, 2'h2)
			`CHK(out.active, 2'h1)
			`CHK(out.sout, 4'h1)
			ba <= 2'h0;
			sa <= 2'h0;
			fa <= 2'h0;
			act <= 2'h0;
			wr(ADDR_CTRL, 32'h30);
			w(6);
			`CHK(out.stage_en, 2'h3)
		end
	endtask
	task automatic t_irq();
		wr(ADDR_IRQ_MK, 32'h1);
		wr(ADDR_IRQ_ST, 32'h3F);
		sa <= 2'h1;
		w(4);
		`CHK(irq, 1'h1)
		rdc(ADDR_IRQ_ST, 32'h1);
		sa <= 2'h0;
		w(4);
		wr(ADDR_IRQ_ST, 32'h1);
		w(3);
		`CHK(irq, 1'h0)
		rdc(ADDR_IRQ_ST, 32'h4);
	endtask
	task automatic t_manual_bus();
		wr(ADDR_MODE, 32'h1);
		wr(ADDR_CTRL, 32'h35);
		wr(ADDR_CTRL, 32'h34);
		w(6);
		`CHK(out.restart_req, 2'h1)
		`CHK(out.sout[1], 1'h1)
		`CHK(out.stage_en, 2'h2)
		wr(ADDR_CTRL, 32'h30);
		wr(ADDR_CTRL, 32'h34);
		w(4);
		`CHK(out.stage_en, 2'h3)
		`CHK(out.restart_req, 2'h0)
		wr(ADDR_CTRL, 32'h21);
		wr(ADDR_CTRL, 32'h20);
		wr(ADDR_CTRL, 32'h24);
		w(4);
		`CHK(out.stage_en, 2'h2)
		wr(ADDR_CTRL, 32'h34);
		w(4);
		`CHK(out.stage_en, 2'h3)
	endtask
	task automatic t_manual_sin();
		wr(ADDR_CTRL, 32'h30);
		wr(ADDR_MAP, 32'h4);
		ack_en <= 2'h1;
		sa <= 2'h1;
		w(4);
		sa <= 2'h0;
		for (int i = 0; i < 60 && out.stage_en !== 2'h3; i++)
			@(posedge hclk);
		`CHK(out.stage_en, 2'h3)
		ack_en <= 2'h0;
	endtask
	task automatic t_iofail();
		wr(ADDR_MODE, 32'h4);
		wr(ADDR_CTRL, 32'h70);
		split <= 2'h1;
		w(40);
		`CHK(out.iofail, 2'h1)
		`CHK(out.stop_trig[0], 1'h1)
		bus(1'h0, ADDR_STATUS, 32'h0);
		`CHK(q[ST_FAULT], 1'h1)
		wr(ADDR_CTRL, 32'h40);
		bus(1'h0, ADDR_STATUS, 32'h0);
		`CHK(q[ST_WARN], 1'h1)
		`CHK(q[ST_FAULT], 1'h0)
		split <= 2'h0;
		w(6);
		wr(ADDR_STATUS, 32'h10);
		w(3);
		`CHK(out.iofail, 2'h0)
	endtask
	// ==========================================================
	// run control
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		t_regs();
		t_sources();
		t_irq();
		t_manual_bus();
		t_manual_sin();
		t_iofail();
		give_verdict();
	end
endmodule
`default_nettype wire
